/* File: asrc_pkg.sv */
// asrc_pkg: constants for the host-side asynchronous ecc sram controller
// assumes a 20 MHz clk and an external 512 K x 32 static memory
//
// Contract
// - memory selected only while all three selects are low
// - read: strobe high, select and output enable low, address held
// - write data meets setup and hold to the terminating edge
// - strobe-led write with oe low lasts float time plus data setup
// - controller never drives lanes while the memory may drive them
// - address valid no later than select going low
// - wait a minimum interval of stable supply before first access
// - that interval is at least 100 microseconds
`default_nettype none

package asrc_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int LANE_W = 8;
    localparam int CLK_NS = 50;
    // times in ns, cycle counts rounded up so no interval is cut short
    localparam int SUPPLY_STABLE_WAIT_NS = 100000;
    localparam int SUPPLY_STABLE_WAIT_CYC =
        (SUPPLY_STABLE_WAIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_TO_FLOAT_TIME_NS = 8;
    localparam int WRITE_DATA_SETUP_TIME_NS = 8;
    localparam int ACCESS_NS = 15;
    localparam int WR_PULSE_CYC = (STROBE_TO_FLOAT_TIME_NS +
        WRITE_DATA_SETUP_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_WAIT_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int TURN_CYC = 1;
    localparam int CNT_W = 16;
endpackage

`default_nettype wire

/* File: asrc_host.sv */
// asrc_host: host controller driving an asynchronous ecc sram over its pins
// assumes the memory pins are combinational and data inputs are resynced
`default_nettype none

module asrc_host #(
    parameter int POWER_WAIT = asrc_pkg::SUPPLY_STABLE_WAIT_CYC
) (
    input wire logic clk,
    input wire logic rst,
    // user request side
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [18:0] req_addr,
    input wire logic [31:0] req_wdata,
    input wire logic [3:0] req_lane_en,
    output logic rsp_valid,
    output logic [31:0] rsp_rdata,
    output logic rsp_corrected,
    output logic power_ready,
    // memory pins
    output logic [18:0] mem_addr,
    output logic select_low_one,
    output logic select_low_two,
    output logic select_low_three,
    output logic output_enable_n,
    output logic write_strobe_n,
    output logic lane0_enable_n,
    output logic lane1_enable_n,
    output logic lane2_enable_n,
    output logic lane3_enable_n,
    input wire logic [31:0] mem_data_i,
    output logic [31:0] mem_data_o,
    output logic [31:0] mem_data_oe,
    input wire logic error_flag
);
    typedef enum logic [2:0] {
        ASRC_POWER, ASRC_IDLE, ASRC_RD, ASRC_RD_END,
        ASRC_WR_SETUP, ASRC_WR, ASRC_WR_END
    } asrc_state_t;

    typedef struct packed {
        asrc_state_t st;
        logic [asrc_pkg::CNT_W-1:0] cnt;
        logic [18:0] addr;
        logic [31:0] wdata;
        logic [3:0] lane_n;
        logic sel_n;
        logic oe_n;
        logic we_n;
        logic drive;
        logic rsp_v;
        logic [31:0] rdata;
        logic corr;
    } asrc_reg_t;

    asrc_reg_t r_q, r_d;

    // three-stage synchronisers for the pins; stage 1 only feeds stage 2
    logic [32:0] sync1_q, sync2_q, sync3_q;
    logic [32:0] stable_q;
    logic [32:0] pin_in;
    assign pin_in = {error_flag, mem_data_i};

    always_ff @(posedge clk) begin
        sync1_q <= pin_in;
        sync2_q <= sync1_q;
        sync3_q <= sync2_q;
    end

    // a bit counts as changed once the second and third stages agree
    genvar g;
    generate
        for (g = 0; g < 33; g++) begin : g_filt
            always_ff @(posedge clk) begin
                if (rst) begin
                    stable_q[g] <= 1'b0;
                end else if (sync2_q[g] == sync3_q[g]) begin
                    stable_q[g] <= sync3_q[g];
                end
            end
        end
    endgenerate

    // next-state logic
    always_comb begin
        r_d = r_q;
        r_d.rsp_v = 1'b0;
        case (r_q.st)
            ASRC_POWER: begin
                // no access before the supply settle time has passed
                if (r_q.cnt >= asrc_pkg::CNT_W'(POWER_WAIT - 1)) begin
                    r_d.st = ASRC_IDLE;
                    r_d.cnt = '0;
                end else begin
                    r_d.cnt = r_q.cnt + 1'b1;
                end
            end
            ASRC_IDLE: begin
                if (req_valid) begin
                    // address is set a cycle before select falls
                    r_d.addr = req_addr;
                    r_d.wdata = req_wdata;
                    r_d.lane_n = ~req_lane_en;
                    r_d.cnt = '0;
                    r_d.st = req_write ? ASRC_WR_SETUP : ASRC_RD;
                end
            end
            ASRC_RD: begin
                // strobe high, select and oe low, address held
                r_d.sel_n = 1'b0;
                r_d.oe_n = 1'b0;
                r_d.cnt = r_q.cnt + 1'b1;
                // extra cycles cover access time plus the input resync
                if (r_q.cnt >= asrc_pkg::CNT_W'(asrc_pkg::RD_WAIT_CYC + 3)) begin
                    r_d.st = ASRC_RD_END;
                end
            end
            ASRC_RD_END: begin
                // only enabled lanes carry data; others read as zero
                for (int i = 0; i < asrc_pkg::LANES; i++) begin
                    r_d.rdata[i*8 +: 8] =
                        r_q.lane_n[i] ? 8'h00 : stable_q[i*8 +: 8];
                end
                r_d.corr = stable_q[32];
                r_d.rsp_v = 1'b1;
                r_d.sel_n = 1'b1;
                r_d.oe_n = 1'b1;
                r_d.cnt = '0;
                r_d.st = ASRC_WR_END; // reuse as bus turnaround
            end
            ASRC_WR_SETUP: begin
                // oe already high, so the memory floats before we drive
                r_d.oe_n = 1'b1;
                r_d.sel_n = 1'b0;
                r_d.drive = 1'b1;
                r_d.st = ASRC_WR;
                r_d.cnt = '0;
            end
            ASRC_WR: begin
                // strobe low long enough for float time plus data setup
                r_d.we_n = 1'b0;
                r_d.cnt = r_q.cnt + 1'b1;
                if (r_q.cnt >= asrc_pkg::CNT_W'(asrc_pkg::WR_PULSE_CYC)) begin
                    r_d.we_n = 1'b1; // strobe rise ends the write
                    r_d.st = ASRC_WR_END;
                    r_d.cnt = '0;
                end
            end
            ASRC_WR_END: begin
                // data held one cycle past the terminating edge
                r_d.sel_n = 1'b1;
                r_d.drive = 1'b0;
                r_d.cnt = r_q.cnt + 1'b1;
                if (r_q.cnt >= asrc_pkg::CNT_W'(asrc_pkg::TURN_CYC)) begin
                    r_d.st = ASRC_IDLE;
                    r_d.cnt = '0;
                end
            end
            default: r_d.st = ASRC_IDLE;
        endcase
    end

    // state register with synchronous reset to a quiet bus
    always_ff @(posedge clk) begin
        if (rst) begin
            r_q <= '{st: ASRC_POWER, cnt: '0, addr: '0, wdata: '0,
                lane_n: 4'hf, sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                drive: 1'b0, rsp_v: 1'b0, rdata: '0, corr: 1'b0};
        end else begin
            r_q <= r_d;
        end
    end

    assign req_ready = (r_q.st == ASRC_IDLE);
    assign power_ready = (r_q.st != ASRC_POWER);
    assign rsp_valid = r_q.rsp_v;
    assign rsp_rdata = r_q.rdata;
    assign rsp_corrected = r_q.corr;
    assign mem_addr = r_q.addr;
    // one combined select drives all three select pins together
    assign select_low_one = r_q.sel_n;
    assign select_low_two = r_q.sel_n;
    assign select_low_three = r_q.sel_n;
    assign output_enable_n = r_q.oe_n;
    assign write_strobe_n = r_q.we_n;
    assign lane0_enable_n = r_q.lane_n[0];
    assign lane1_enable_n = r_q.lane_n[1];
    assign lane2_enable_n = r_q.lane_n[2];
    assign lane3_enable_n = r_q.lane_n[3];
    assign mem_data_o = r_q.wdata;

    // drive only enabled lanes, and only while oe is high
    generate
        for (g = 0; g < asrc_pkg::LANES; g++) begin : g_oe
            assign mem_data_oe[g*8 +: 8] =
                {8{r_q.drive & ~r_q.lane_n[g] & r_q.oe_n}};
        end
    endgenerate
endmodule

`default_nettype wire

/* File: asrc_mem_model.sv */
// asrc_mem_model: behavioural 512 K x 32 memory with error flag
// assumes its pins come straight from asrc_host, with no delays
`default_nettype none

module asrc_mem_model #(
    parameter logic [18:0] ERR_ADDR = 19'h00123
) (
    input wire logic [18:0] addr,
    input wire logic sel1_n,
    input wire logic sel2_n,
    input wire logic sel3_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [3:0] lane_n,
    input wire logic [31:0] host_d,
    input wire logic [31:0] host_oe,
    output logic [31:0] pin_d,
    output logic err
);
    logic [31:0] mem [int];
    logic [31:0] q;
    logic [31:0] m;
    wire sel = !(sel1_n | sel2_n | sel3_n);
    wire rd = sel && !oe_n && we_n;
    wire wr = sel && !we_n;
    // floating bits show the inverse so a stale value never passes
    always_comb begin
        q = mem.exists(addr) ? mem[addr] : 32'h0;
        for (int i = 0; i < 4; i++) m[i*8 +: 8] = {8{!lane_n[i]}};
        pin_d = (host_d & host_oe) | (q & m & {32{rd}} & ~host_oe);
        pin_d = pin_d | (~q & ~host_oe & ~(m & {32{rd}}));
        err = rd ? addr == ERR_ADDR : addr != ERR_ADDR;
    end
    // store on the first rising edge of strobe or select
    always @(negedge wr) mem[addr] = (q & ~m) | (host_d & m);
endmodule

`default_nettype wire

/* File: asrc_host_assertions.sv */
// asrc_host_checker: pin protocol properties of asrc_host
// assumes the bind below and a synchronous active high rst
`default_nettype none

module asrc_host_checker #(
    parameter int POWER_WAIT = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_write,
    input wire logic rsp_valid,
    input wire logic [18:0] mem_addr,
    input wire logic select_low_one,
    input wire logic select_low_two,
    input wire logic select_low_three,
    input wire logic output_enable_n,
    input wire logic write_strobe_n,
    input wire logic [31:0] mem_data_o,
    input wire logic [31:0] mem_data_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    int up_q;
    // cycles since reset release, saturating
    always_ff @(posedge clk) up_q <= rst ? 0 : up_q + (up_q < POWER_WAIT);
    sequence strobe_low;
        !write_strobe_n && !select_low_one && |mem_data_oe;
    endsequence
    sel_match_a: assert property (select_low_one == select_low_two &&
        select_low_one == select_low_three) else $error("selects differ");
    no_clash_a: assert property (|mem_data_oe |-> output_enable_n)
        else $error("host drives while memory may drive");
    read_strobe_a: assert property (!output_enable_n && !select_low_one
        |-> write_strobe_n) else $error("strobe low during read");
    addr_hold_a: assert property (!select_low_one |-> $stable(mem_addr))
        else $error("address moved while selected");
    power_gap_a: assert property (!select_low_one |-> up_q >= POWER_WAIT)
        else $error("access before power wait");
    // one clock of strobe low already exceeds float time plus data setup
    wr_pulse_a: assert property ($fell(write_strobe_n) |-> strobe_low ##1
        (write_strobe_n && !select_low_one && |mem_data_oe))
        else $error("write strobe pulse wrong");
    wr_end_a: assert property ($rose(write_strobe_n) |-> $stable(mem_data_o)
        && $past(|mem_data_oe)) else $error("data not held at write end");
    rd_answer_a: assert property (req_valid && req_ready && !req_write
        |-> ##7 rsp_valid) else $error("read answer late");
endmodule

bind asrc_host asrc_host_checker #(.POWER_WAIT(POWER_WAIT)) u_chk (.clk, .rst,
    .req_valid, .req_ready, .req_write, .rsp_valid, .mem_addr, .select_low_one,
    .select_low_two, .select_low_three, .output_enable_n, .write_strobe_n,
    .mem_data_o, .mem_data_oe);

`default_nettype wire

/* File: tb_asrc_host.sv */
// tb_asrc_host: self-checking bench for asrc_host with a memory model
// assumes asrc_mem_model and the bound checker are compiled first
`default_nettype none

module tb_asrc_host;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [18:0] BAD = 19'h00123;
    logic clk = 0, rst = 1, req_valid = 0, req_write = 0;
    logic [18:0] req_addr = '0, mem_addr;
    logic [31:0] req_wdata = '0, rsp_rdata, mem_data_i, mem_data_o, mem_data_oe;
    logic [3:0] req_lane_en = '0;
    logic req_ready, rsp_valid, rsp_corrected, power_ready, select_low_one,
        select_low_two, select_low_three, output_enable_n, write_strobe_n,
        lane0_enable_n, lane1_enable_n, lane2_enable_n, lane3_enable_n,
        error_flag;
    int miscompares = 0, checks = 0;
    // 20 MHz clock
    always #25 clk = ~clk;
    asrc_host #(.POWER_WAIT(10)) u_asrc_host (.clk, .rst, .req_valid,
        .req_ready, .req_write, .req_addr, .req_wdata, .req_lane_en,
        .rsp_valid, .rsp_rdata, .rsp_corrected, .power_ready, .mem_addr,
        .select_low_one, .select_low_two, .select_low_three, .output_enable_n,
        .write_strobe_n, .lane0_enable_n, .lane1_enable_n, .lane2_enable_n,
        .lane3_enable_n, .mem_data_i, .mem_data_o, .mem_data_oe, .error_flag);
    asrc_mem_model #(.ERR_ADDR(BAD)) u_asrc_mem_model (.addr(mem_addr),
        .sel1_n(select_low_one), .sel2_n(select_low_two),
        .sel3_n(select_low_three), .oe_n(output_enable_n),
        .we_n(write_strobe_n), .lane_n({lane3_enable_n, lane2_enable_n,
        lane1_enable_n, lane0_enable_n}), .host_d(mem_data_o),
        .host_oe(mem_data_oe), .pin_d(mem_data_i), .err(error_flag));
    task automatic test_done;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one request at a falling edge; reads wait for the answer, bounded
    task automatic xfer(input logic w, input logic [18:0] a,
        input logic [31:0] d, input logic [3:0] l, input logic [32:0] exp);
        int n = 0;
        while (req_ready !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        {req_valid, req_write, req_addr, req_wdata, req_lane_en} = {1'b1, w,
            a, d, l};
        @(negedge clk);
        req_valid = 0;
        while (!w && rsp_valid !== 1'b1 && n < 120) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 100 || (!w && rsp_valid !== 1'b1)) begin
            miscompares++;
            test_done();
        end
        if (!w) chk({rsp_rdata}, exp[31:0]);
        if (!w) chk({31'h0, rsp_corrected}, {31'h0, exp[32]});
    endtask
    task automatic t_word;
        xfer(1, 19'h7ffff, 32'h89abcdef, 4'hf, 0);
        xfer(0, 19'h7ffff, 0, 4'hf, {1'b0, 32'h89abcdef});
    endtask
    task automatic t_lanes;
        xfer(1, 19'h00005, 32'h0, 4'hf, 0);
        for (int i = 0; i < 4; i++) begin
            xfer(1, 19'h00005, 32'hffffffff, 4'h1 << i, 0);
            xfer(0, 19'h00005, 0, 4'h1 << i, 33'hff << i*8);
            xfer(0, 19'h00005, 0, 4'h1, 33'hff);
            xfer(0, 19'h00005, 0, 4'hf, {1'b0, 32'hff_ffff_ff >> (24 - i*8)});
        end
    endtask
    task automatic t_err;
        xfer(1, BAD, 32'h5a5a1234, 4'hf, 0);
        xfer(0, BAD, 0, 4'hf, {1'b1, 32'h5a5a1234});
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rst = 0;
        chk({31'h0, power_ready}, 32'h0);
        t_word();
        chk({31'h0, power_ready}, 32'h1);
        t_lanes();
        t_err();
        test_done();
    end
endmodule

`default_nettype wire
